/* design/adc_ctl_pkg.sv */
package adc_ctl_pkg;

	// register byte addresses on the bus, one aligned word each
	localparam logic [5:0] OFS_CTRL_A      = 6'h00;
	localparam logic [5:0] OFS_RESULT_LOW  = 6'h04;
	localparam logic [5:0] OFS_RESULT_HIGH = 6'h08;
	localparam logic [5:0] OFS_CTRL_B      = 6'h0c;
	localparam logic [5:0] OFS_BUF_LOW     = 6'h10;
	localparam logic [5:0] OFS_BUF_HIGH    = 6'h14;
	localparam logic [5:0] OFS_MISC        = 6'h18;
	localparam logic [5:0] OFS_COMP        = 6'h1c;
	localparam logic [5:0] OFS_FORMAT      = 6'h20;

	// field positions
	localparam int CA_ON    = 7;
	localparam int CA_START = 6;
	localparam int CA_AUTO  = 5;
	localparam int CA_DONE  = 4;
	localparam int CA_IE    = 3;
	localparam int CB_TWO   = 7;
	localparam int CB_RSVD  = 3;
	localparam int BH_LSB   = 4;
	localparam int MS_EXT   = 2;
	localparam int MS_INT   = 1;
	localparam int CP_OFF   = 7;
	localparam int CP_IREF  = 6;
	localparam int CP_OUT   = 5;
	localparam int CP_FLAG  = 4;
	localparam int CP_IE    = 3;
	localparam int CP_CAPT  = 2;

	// values after reset
	localparam logic [7:0]  RST_REG8   = 8'h00;
	localparam logic [9:0]  RST_RESULT = 10'h000;
	localparam logic [6:0]  RST_DIV    = 7'h00;

	// result limits
	localparam logic [9:0]  UNI_FULL   = 10'h3ff;
	localparam logic signed [10:0] BIP_MAX = 11'sh1ff;
	localparam logic signed [10:0] BIP_MIN = -11'sh200;

	// trigger source codes
	localparam logic [2:0]  TRIG_FREE  = 3'h0;

	// comparator interrupt modes
	typedef enum logic [1:0]
	{
		COMP_TOGGLE = 2'h0,
		COMP_RSVD   = 2'h1,
		COMP_FALL   = 2'h2,
		COMP_RISE   = 2'h3
	} comp_mode_e;

	// avalon request as seen by the slave
	typedef struct packed
	{
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} bus_req_s;

	// finished conversion from the analog core
	typedef struct packed
	{
		logic               done;
		logic signed [10:0] raw;
	} conv_in_s;

endpackage : adc_ctl_pkg

/* design/adc_control_result_regs.sv */
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_control_result_regs
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire adc_ctl_pkg::bus_req_s i_bus,
	output logic                       o_waitrequest,
	output logic [31:0]                o_readdata,
	input  wire adc_ctl_pkg::conv_in_s i_conv,
	input  wire logic [5:0]            i_periph_flags,
	input  wire logic                  i_comp_raw,
	input  wire logic [10:0]           i_pin_level,
	output logic                       o_conv_start,
	output logic                       o_conv_clk_en,
	output logic                       o_conv_abort,
	output logic                       o_two_sided,
	output logic                       o_ext_ref_on,
	output logic                       o_int_ref_out_on,
	output logic                       o_current_src_on,
	output logic [10:0]                o_pin_buffer_off,
	output logic [10:0]                o_pin_read,
	output logic                       o_comp_irq
);
	import adc_ctl_pkg::*;

	// every flip-flop of the block except the two reset synchroniser flops lives in this one record
	typedef struct packed
	{
		logic        waitreq;
		logic [31:0] rdata;
		logic        converter_on;
		logic        busy;
		logic        auto_trigger_on;
		logic        done_flag;
		logic        done_ie;
		logic [2:0]  clock_divider_select;
		logic        left_justify_result;
		logic        two_sided_select;
		logic        comp_mux_en;
		logic [1:0]  comp_ref_sel;
		logic [2:0]  trigger_source_select;
		logic [7:0]  low_pin_buffer_off_bits;
		logic [2:0]  high_pin_buffer_off_bits;
		logic [2:0]  misc_bits;
		logic        comp_off;
		logic        comp_int_ref;
		logic        comp_flag;
		logic        comp_ie;
		logic        comp_capture;
		logic [1:0]  comp_mode;
		logic [9:0]  result;
		logic        locked;
		logic        trig_prev;
		logic [2:0]  sel_prev;
		logic [6:0]  div_cnt;
		logic        clk_en;
		logic        start;
		logic        abort;
		logic        comp_meta;
		logic        comparator_result;
		logic        comp_prev;
		logic [10:0] pin_meta;
		logic [10:0] pin_sync;
		logic [10:0] pin_read;
		logic        comp_irq;
	} ctl_state_s;

	ctl_state_s st;
	ctl_state_s next_st;
	logic       rst_meta_n;
	logic       rst_sync_n;

	// reset is released through two flops so that no flop leaves reset
	// in a different cycle from its neighbours
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// decoded access strobes, valid only at the edge that ends the wait
	logic       acc;
	logic       wr8;
	logic       rd;
	logic [7:0] wd;
	logic [6:0] div_last;
	logic [7:0] trig_src;
	logic       trig_now;
	logic       trig_edge;
	logic       sw_start;
	logic       conv_finish;
	logic [9:0] shaped;
	logic [7:0] res_low;
	logic [7:0] res_high;
	logic [7:0] rmux;
	logic       comp_event;

	always_comb
	begin
		acc      = (i_bus.read | i_bus.write) & ~st.waitreq;
		wr8      = acc & i_bus.write & i_bus.byteenable[0];
		rd       = acc & i_bus.read;
		wd       = i_bus.writedata[7:0];
	end

	// divider terminal count: codes 0 and 1 both divide by two
	always_comb
	begin
		case (st.clock_divider_select)
			3'h0, 3'h1: div_last = 7'h01;
			3'h2:       div_last = 7'h03;
			3'h3:       div_last = 7'h07;
			3'h4:       div_last = 7'h0f;
			3'h5:       div_last = 7'h1f;
			3'h6:       div_last = 7'h3f;
			default:    div_last = 7'h7f;
		endcase
	end

	// trigger sources; the free-running source is the done flag itself
	always_comb
	begin
		trig_src  = {i_periph_flags, st.comp_flag, st.done_flag};
		trig_now  = trig_src[st.trigger_source_select];
		// a new selection whose flag is set while the old one was clear is an edge, except free run
		trig_edge = trig_now & ~st.trig_prev
			& ~((st.trigger_source_select == TRIG_FREE)
			& (st.sel_prev != TRIG_FREE));
	end

	// shape the raw difference from the core into the stored code
	always_comb
	begin
		if (st.two_sided_select)
		begin
			// clamp to 9 magnitude bits plus sign
			if (i_conv.raw > BIP_MAX)
				shaped = BIP_MAX[9:0];
			else if (i_conv.raw < BIP_MIN)
				shaped = BIP_MIN[9:0];
			else
				shaped = i_conv.raw[9:0];
		end
		else if (i_conv.raw <= 11'sh000)
			shaped = UNI_FULL;
		else if (i_conv.raw[10:0] > {1'b0, UNI_FULL})
			shaped = UNI_FULL;
		else
			shaped = i_conv.raw[9:0];
	end

	// justification is applied at read time so the bit acts at once
	always_comb
	begin
		if (st.left_justify_result)
		begin
			res_high = st.result[9:2];
			res_low  = {st.result[1:0], 6'h00};
		end
		else
		begin
			res_high = {6'h00, st.result[9:8]};
			res_low  = st.result[7:0];
		end
	end

	// comparator interrupt event from the synchronised output
	always_comb
	begin
		case (comp_mode_e'(st.comp_mode))
			COMP_TOGGLE: comp_event = st.comparator_result ^ st.comp_prev;
			COMP_FALL:   comp_event = ~st.comparator_result & st.comp_prev;
			COMP_RISE:   comp_event = st.comparator_result & ~st.comp_prev;
			default:     comp_event = 1'b0; // reserved code fires nothing
		endcase
		comp_event = comp_event & ~st.comp_off;
	end

	// read multiplexer; reserved bits come back as zero
	always_comb
	begin
		case (i_bus.address)
			OFS_CTRL_A:
				rmux = {st.converter_on, st.busy, st.auto_trigger_on,
					st.done_flag, st.done_ie, st.clock_divider_select};
			OFS_RESULT_LOW:  rmux = res_low;
			OFS_RESULT_HIGH: rmux = res_high;
			OFS_CTRL_B:
				rmux = {st.two_sided_select, st.comp_mux_en,
					st.comp_ref_sel, 1'b0,
					st.trigger_source_select};
			OFS_BUF_LOW:     rmux = st.low_pin_buffer_off_bits;
			OFS_BUF_HIGH:
				rmux = {1'b0, st.high_pin_buffer_off_bits, 4'h0};
			OFS_MISC:        rmux = {5'h00, st.misc_bits};
			OFS_COMP:
				rmux = {st.comp_off, st.comp_int_ref, st.comparator_result,
					st.comp_flag, st.comp_ie, st.comp_capture,
					st.comp_mode};
			OFS_FORMAT:      rmux = {7'h00, st.left_justify_result};
			default:         rmux = RST_REG8;
		endcase
	end

	always_comb
	begin
		sw_start    = wr8 & (i_bus.address == OFS_CTRL_A)
			& wd[CA_START] & wd[CA_ON];
		conv_finish = st.busy & i_conv.done;
	end

	// next-state logic for the whole block
	always_comb
	begin
		next_st = st;

		// bus handshake: one wait cycle, then the access completes
		next_st.waitreq = ~((i_bus.read | i_bus.write) & st.waitreq);
		if (~next_st.waitreq & i_bus.read)
			next_st.rdata = {24'h000000, rmux};
		else
			next_st.rdata = 32'h00000000;

		// register writes; result bytes have no write path at all
		if (wr8)
		begin
			case (i_bus.address)
				OFS_CTRL_A:
				begin
					next_st.converter_on         = wd[CA_ON];
					next_st.auto_trigger_on      = wd[CA_AUTO];
					next_st.done_ie              = wd[CA_IE];
					next_st.clock_divider_select = wd[2:0];
					if (wd[CA_DONE])
						next_st.done_flag = 1'b0;
				end
				OFS_CTRL_B:
				begin
					next_st.two_sided_select      = wd[CB_TWO];
					next_st.comp_mux_en           = wd[6];
					next_st.comp_ref_sel          = wd[5:4];
					next_st.trigger_source_select = wd[2:0];
				end
				OFS_BUF_LOW:
					next_st.low_pin_buffer_off_bits = wd;
				OFS_BUF_HIGH:
					next_st.high_pin_buffer_off_bits = wd[6:BH_LSB];
				OFS_MISC:
					next_st.misc_bits = wd[2:0];
				OFS_COMP:
				begin
					next_st.comp_off     = wd[CP_OFF];
					next_st.comp_int_ref = wd[CP_IREF];
					next_st.comp_ie      = wd[CP_IE];
					next_st.comp_capture = wd[CP_CAPT];
					next_st.comp_mode    = wd[1:0];
					if (wd[CP_FLAG])
						next_st.comp_flag = 1'b0;
				end
				OFS_FORMAT:
					next_st.left_justify_result = wd[0];
				default:
					next_st.misc_bits = st.misc_bits;
			endcase
		end

		// result lock: taken in the cycle the low byte is captured, so a
		// conversion ending in that same cycle cannot split the pair
		if (~next_st.waitreq & i_bus.read
			& (i_bus.address == OFS_RESULT_LOW))
			next_st.locked = 1'b1;
		else if (rd & (i_bus.address == OFS_RESULT_HIGH))
			next_st.locked = 1'b0;

		// converter clock enable from the prescaler
		if (!st.converter_on || st.div_cnt >= div_last)
			next_st.div_cnt = RST_DIV;
		else
			next_st.div_cnt = st.div_cnt + 7'h01;
		next_st.clk_en = st.converter_on & (st.div_cnt >= div_last);

		// trigger edge tracking
		next_st.trig_prev = trig_now;
		next_st.sel_prev  = st.trigger_source_select;

		// start requests; turning the converter off ends a conversion
		next_st.start = 1'b0;
		next_st.abort = 1'b0;
		if (!st.converter_on)
		begin
			next_st.abort = st.busy;
			next_st.busy  = 1'b0;
		end
		else if (conv_finish)
			next_st.busy = 1'b0;
		if ((sw_start | (st.converter_on & st.auto_trigger_on
			& trig_edge)) & ~st.busy & ~next_st.start)
		begin
			next_st.start = 1'b1;
			next_st.busy  = 1'b1;
		end

		// completion sets the flag; a set in the same cycle beats a clear
		if (conv_finish & st.converter_on)
		begin
			next_st.done_flag = 1'b1;
			if (!next_st.locked)
				next_st.result = shaped;
		end

		// comparator output and pins pass two flops before use
		next_st.comp_meta         = i_comp_raw;
		next_st.comparator_result = st.comp_meta & ~st.comp_off;
		next_st.comp_prev         = st.comparator_result;
		if (comp_event)
			next_st.comp_flag = 1'b1;
		next_st.comp_irq = next_st.comp_flag & next_st.comp_ie;

		next_st.pin_meta = i_pin_level;
		next_st.pin_sync = st.pin_meta;
		// mask with the new bits so a freshly disabled pin never shows a one
		next_st.pin_read = st.pin_sync
			& ~{next_st.high_pin_buffer_off_bits,
			next_st.low_pin_buffer_off_bits};
	end

	// single register stage for the whole state record
	always_ff @(posedge i_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			st         <= '0;
			st.waitreq <= 1'b1;
			st.result  <= RST_RESULT;
		end
		else
			st <= next_st;
	end

	// outputs straight from the state flops
	assign o_waitrequest    = st.waitreq;
	assign o_readdata       = st.rdata;
	assign o_conv_start     = st.start;
	assign o_conv_clk_en    = st.clk_en;
	assign o_conv_abort     = st.abort;
	assign o_two_sided      = st.two_sided_select;
	assign o_ext_ref_on     = st.misc_bits[MS_EXT];
	assign o_int_ref_out_on = st.misc_bits[MS_INT];
	assign o_current_src_on = st.misc_bits[0];
	assign o_pin_buffer_off = {st.high_pin_buffer_off_bits,
		st.low_pin_buffer_off_bits};
	assign o_pin_read       = st.pin_read;
	assign o_comp_irq       = st.comp_irq;

endmodule : adc_control_result_regs
`default_nettype wire

/* dv/adc_ctl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_assertions
(
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire adc_ctl_pkg::bus_req_s i_bus,
	input wire logic                  o_waitrequest,
	input wire logic [31:0]           o_readdata,
	input wire adc_ctl_pkg::conv_in_s i_conv,
	input wire logic [5:0]            i_periph_flags,
	input wire logic                  o_conv_start,
	input wire logic                  o_conv_clk_en,
	input wire logic                  o_conv_abort,
	input wire logic                  o_two_sided,
	input wire logic [10:0]           o_pin_buffer_off,
	input wire logic [10:0]           o_pin_read
);
	import adc_ctl_pkg::*;
	logic       wr;
	logic       rd_b;
	logic       on;
	logic       auto;
	logic       busy;
	logic       arm;
	logic [2:0] div;
	logic [2:0] src;
	logic [7:0] cnt;
	logic [7:0] fac;
	// only accepted writes move the shadows
	assign wr = i_bus.write && !o_waitrequest && i_bus.byteenable[0];
	assign rd_b = i_bus.read && !o_waitrequest;
	assign fac = (div < 3'h2) ? 8'h02 : (8'h01 << div);
	// period is judged only after a full pulse gap since the last divider write
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			{on, auto, busy, arm, div, src, cnt} <= '0;
		end
		else
		begin
			cnt <= o_conv_clk_en ? 8'h00 : cnt + 8'h01;
			if (o_conv_clk_en)
				arm <= 1'b1;
			if (wr && i_bus.address == OFS_CTRL_A)
			begin
				on <= i_bus.writedata[CA_ON];
				auto <= i_bus.writedata[CA_AUTO];
				div <= i_bus.writedata[2:0];
				arm <= 1'b0;
			end
			if (wr && i_bus.address == OFS_CTRL_B)
				src <= i_bus.writedata[2:0];
			if (o_conv_start)
				busy <= 1'b1;
			else if (i_conv.done || o_conv_abort)
				busy <= 1'b0;
		end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	a_clk_period:
		assert property (o_conv_clk_en && arm |-> cnt == fac - 8'h01)
		else $error("converter clock period wrong");
	a_ctlb_rsvd:
		assert property (rd_b && i_bus.address == OFS_CTRL_B
			|-> !o_readdata[CB_RSVD]) else $error("control b bit 3 set");
	a_misc_rsvd:
		assert property (rd_b && i_bus.address == OFS_MISC
			|-> o_readdata[7:3] == 5'h00) else $error("misc high bits set");
	a_pin_low:
		assert property ((o_pin_read[7:0] & o_pin_buffer_off[7:0]) == 8'h00)
		else $error("disabled low pin reads one");
	a_pin_high:
		assert property ((o_pin_read[10:8] & o_pin_buffer_off[10:8]) == 3'h0)
		else $error("disabled high pin reads one");
	a_two_sided:
		assert property (wr && i_bus.address == OFS_CTRL_B |-> ##2
			o_two_sided == $past(i_bus.writedata[CB_TWO], 2))
		else $error("two sided select not followed");
	a_trig_edge:
		assert property (on && auto && !busy && !o_conv_start && src > 3'h1
			&& $rose(i_periph_flags[src - 3'h2]) |-> ##[1:4] o_conv_start)
		else $error("flag edge started nothing");
	a_free_quiet:
		assert property (wr && i_bus.address == OFS_CTRL_B && !busy
			&& i_bus.writedata[2:0] == TRIG_FREE |=> !o_conv_start [*2])
		else $error("free running select started a conversion");
	a_off_abort:
		assert property (wr && i_bus.address == OFS_CTRL_A && busy
			&& !i_conv.done && !i_bus.writedata[CA_ON] |-> ##2 o_conv_abort)
		else $error("converter off did not abort");
endmodule : adc_ctl_assertions
bind adc_control_result_regs adc_ctl_assertions chk
(
	.i_clk, .i_rst_n, .i_bus, .o_waitrequest, .o_readdata, .i_conv,
	.i_periph_flags, .o_conv_start, .o_conv_clk_en, .o_conv_abort, .o_two_sided,
	.o_pin_buffer_off, .o_pin_read
);
`default_nettype wire

/* dv/adc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
(
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_start,
	input  wire logic               i_abort,
	input  wire logic signed [10:0] i_value,
	input  wire logic [3:0]         i_delay,
	output adc_ctl_pkg::conv_in_s   o_conv
);
	import adc_ctl_pkg::*;
	logic [3:0] left;
	// result ends i_delay cycles after start; raw is scrambled outside done
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			left <= 4'h0;
			o_conv <= '0;
		end
		else
		begin
			o_conv.done <= left == 4'h1 && !i_abort;
			o_conv.raw <= (left == 4'h1) ? i_value : ~o_conv.raw;
			if (i_abort)
				left <= 4'h0;
			else if (i_start)
				left <= i_delay;
			else if (left != 4'h0)
				left <= left - 4'h1;
		end
endmodule : adc_core_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adc_ctl_pkg::*;
	logic               i_clk = 1'b0;
	logic               i_rst_n = 1'b0;
	bus_req_s           i_bus = '0;
	conv_in_s           i_conv;
	logic [5:0]         i_periph_flags = 6'h0;
	logic               i_comp_raw = 1'b0;
	logic [10:0]        i_pin_level = 11'h0;
	logic signed [10:0] value = 11'sd0;
	logic [3:0]         dly = 4'h1;
	logic               o_waitrequest, o_conv_start, o_conv_clk_en;
	logic               o_conv_abort, o_two_sided, o_comp_irq;
	logic               o_ext_ref_on, o_int_ref_out_on, o_current_src_on;
	logic [31:0]        o_readdata;
	logic [10:0]        o_pin_buffer_off, o_pin_read;
	logic [31:0]        q[$];
	int                 err_total = 0;
	int                 n_tests = 0;
	int                 starts = 0;
	int                 aborts = 0;
	integer             seed = 32'hafb8;
	always #4 i_clk = ~i_clk;
	adc_control_result_regs uut (.i_clk, .i_rst_n, .i_bus, .o_waitrequest,
		.o_readdata, .i_conv, .i_periph_flags, .i_comp_raw, .i_pin_level,
		.o_conv_start, .o_conv_clk_en, .o_conv_abort, .o_two_sided,
		.o_ext_ref_on, .o_int_ref_out_on, .o_current_src_on,
		.o_pin_buffer_off, .o_pin_read, .o_comp_irq);
	adc_core_model core (.i_clk, .i_rst_n, .i_start(o_conv_start),
		.i_abort(o_conv_abort), .i_value(value), .i_delay(dly), .o_conv(i_conv));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic fin(input string s);
		$display("end of %s", s);
	endtask : fin
	// request stands until waitrequest is sampled low at a rising edge
	task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
		@(posedge i_clk);
		i_bus <= '{a, !w, w, 4'h1, {24'h0, d}};
		@(posedge i_clk);
		while (o_waitrequest)
			@(posedge i_clk);
		i_bus <= '0;
	endtask : acc
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		q.push_back({24'h0, e});
		acc(a, 1'b0, 8'h00);
	endtask : rd
	// one conversion with format l, two sided b and core delay d
	task automatic go(input logic signed [10:0] v, input logic l,
		input logic b, input logic [3:0] d);
		value <= v;
		dly <= d;
		acc(OFS_FORMAT, 1'b1, {7'h0, l});
		acc(OFS_CTRL_B, 1'b1, {b, 7'h0});
		acc(OFS_CTRL_A, 1'b1, 8'hd0);
		for (int i = 0; i < 100 && !i_conv.done; i++)
			@(posedge i_clk);
		repeat (2) @(posedge i_clk);
	endtask : go
	function automatic logic [9:0] res(input logic signed [10:0] r,
		input logic b);
		if (b)
			return (r > 11'sd511) ? 10'h1ff : (r < -11'sd512) ? 10'h200 : r[9:0];
		return (r <= 11'sd0) ? 10'h3ff : r[9:0];
	endfunction : res
	// read answers are taken at the edge that finishes the access
	always @(posedge i_clk)
		if (i_bus.read && !o_waitrequest)
			check(o_readdata, q.pop_front());
	always @(posedge i_clk)
		if (o_conv_start)
			starts <= starts + 1;
	always @(posedge i_clk)
		if (o_conv_abort)
			aborts <= aborts + 1;
	initial
	begin
		logic [31:0] r;
		logic [9:0]  e;
		int          n0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		// reset values, result words and an unmapped word
		rd(OFS_MISC, 8'h00);
		rd(OFS_RESULT_LOW, 8'h00);
		rd(OFS_RESULT_HIGH, 8'h00);
		rd(6'h24, 8'h00);
		acc(OFS_CTRL_B, 1'b1, 8'h87);
		rd(OFS_CTRL_B, 8'h87);
		acc(OFS_MISC, 1'b1, 8'h07);
		rd(OFS_MISC, 8'h07);
		check({29'h0, o_ext_ref_on, o_int_ref_out_on, o_current_src_on},
			32'h7);
		fin("registers");
		// random pin levels against random buffer-off masks
		repeat (4)
		begin
			r = $random(seed);
			i_pin_level <= r[26:16];
			acc(OFS_BUF_LOW, 1'b1, r[7:0]);
			acc(OFS_BUF_HIGH, 1'b1, {1'b0, r[14:12], 4'h0});
			rd(OFS_BUF_HIGH, {1'b0, r[14:12], 4'h0});
			check({21'h0, o_pin_read},
				{21'h0, r[26:16] & ~{r[14:12], r[7:0]}});
		end
		fin("pins");
		// each format, zero first, low byte read before high
		for (int k = 0; k < 8; k++)
		begin
			r = (k < 2) ? 32'h0 : $random(seed);
			go(r[10:0], k[0], k[1], k[2] ? 4'hc : 4'h1);
			e = res(r[10:0], k[1]);
			rd(OFS_RESULT_LOW, k[0] ? {e[1:0], 6'h0} : e[7:0]);
			rd(OFS_RESULT_HIGH, k[0] ? e[9:2] : {6'h0, e[9:8]});
		end
		fin("convert");
		// a low read holds both bytes through the next conversion
		go(11'sd300, 1'b0, 1'b0, 4'h2);
		acc(OFS_RESULT_LOW, 1'b1, 8'h5a);
		rd(OFS_RESULT_LOW, 8'h2c);
		go(11'sd5, 1'b0, 1'b0, 4'h2);
		rd(OFS_RESULT_HIGH, 8'h01);
		fin("lock");
		// switching off during a long conversion must abort it once
		value <= 11'sd7;
		dly <= 4'hc;
		acc(OFS_CTRL_A, 1'b1, 8'hd0);
		acc(OFS_CTRL_A, 1'b1, 8'h00);
		repeat (20) @(posedge i_clk);
		check(32'(aborts), 32'h1);
		dly <= 4'h2;
		fin("abort");
		for (int k = 0; k < 8; k++)
		begin
			acc(OFS_CTRL_A, 1'b1, {5'h10, k[2:0]});
			repeat (400) @(posedge i_clk);
		end
		fin("divider");
		// every peripheral source starts exactly one conversion
		acc(OFS_CTRL_A, 1'b1, 8'hb0);
		for (int s = 2; s < 8; s++)
		begin
			acc(OFS_CTRL_B, 1'b1, {5'h0, s[2:0]});
			n0 = starts;
			i_periph_flags[s - 2] <= 1'b1;
			repeat (20) @(posedge i_clk);
			i_periph_flags <= 6'h0;
			check(32'(starts - n0), 32'h1);
		end
		acc(OFS_CTRL_B, 1'b1, 8'h03);
		i_periph_flags <= 6'h01;
		n0 = starts;
		acc(OFS_CTRL_B, 1'b1, 8'h02);
		repeat (20) @(posedge i_clk);
		check(32'(starts - n0), 32'h1);
		// drop the old source first so only the suppression keeps it quiet
		i_periph_flags <= 6'h0;
		n0 = starts;
		acc(OFS_CTRL_B, 1'b1, 8'h00);
		repeat (20) @(posedge i_clk);
		check(32'(starts - n0), 32'h0);
		acc(OFS_CTRL_A, 1'b1, 8'h90);
		fin("trigger");
		// each interrupt mode meets one rising and one falling edge
		for (int m = 0; m < 4; m++)
			for (int x = 0; x < 2; x++)
			begin
				acc(OFS_COMP, 1'b1, {3'h0, 2'h3, 1'b0, m[1:0]});
				i_comp_raw <= !x[0];
				repeat (10) @(posedge i_clk);
				e[0] = m == 0 || (m == 3 && x == 0) || (m == 2 && x == 1);
				check({31'h0, o_comp_irq}, {31'h0, e[0]});
				rd(OFS_COMP, {2'h0, !x[0], e[0], 2'h2, m[1:0]});
			end
		fin("comparator");
		stop_test;
	end
	// expected run is near 3900 cycles; allow 20000, about five times that
	initial
	begin
		#160000;
		err_total++;
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
